// ### core/hpp_pkg.sv
// ***************************************************************
// constants shared by both ends of the handshake parallel port
// ***************************************************************
// assumes a single 20 MHz clock shared by every file of the design
package hpp_pkg;
    // clock and bus timing
    localparam int CLOCK_NS = 50;
    localparam int ENABLE_HIGH_NS = 100; // least high time of the enable clock
    localparam int ENABLE_HIGH_CYCLES = (ENABLE_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam logic [1:0] ENABLE_COUNT_LAST = 2'(ENABLE_HIGH_CYCLES - 1);
    localparam logic [1:0] ENABLE_COUNT_ZERO = 2'h0;
    localparam logic [1:0] ENABLE_COUNT_STEP = 2'h1;

    // device register offsets on the processor bus
    localparam logic [1:0] REG_PORT_A = 2'h0;
    localparam logic [1:0] REG_CTRL_A = 2'h1;
    localparam logic [1:0] REG_PORT_B = 2'h2;
    localparam logic [1:0] REG_CTRL_B = 2'h3;

    // port control register fields
    localparam int CTRL_EDGE_RISING = 0; // 1: strobe active on rising edge
    localparam int CTRL_HANDSHAKE = 1; // 1: second control line is a handshake output
    localparam int CTRL_DATA_SEL = 2; // 1: data register, 0: direction register
    localparam int CTRL_FLAG = 7; // read only strobe flag
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;

    // host controller register offsets on the software port
    localparam logic [3:0] HOST_REG_TARGET = 4'h0;
    localparam logic [3:0] HOST_REG_WDATA = 4'h1;
    localparam logic [3:0] HOST_REG_GO = 4'h2;
    localparam logic [3:0] HOST_REG_STATUS = 4'h3;
    localparam logic [3:0] HOST_REG_RDATA = 4'h4;
    localparam logic [3:0] HOST_REG_PA_OUT = 4'h5;
    localparam logic [3:0] HOST_REG_PA_OE = 4'h6;
    localparam logic [3:0] HOST_REG_STROBES = 4'h7;
    localparam logic [3:0] HOST_REG_PB_LEVEL = 4'h8;

    // host register fields
    localparam int TARGET_READ = 2; // target bit 2: 1 read, 0 write
    localparam int STROBE_READY = 0;
    localparam int STROBE_ACCEPT = 1;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_IRQ = 1;
    localparam int STATUS_TAKEN = 2;
    localparam int STATUS_VALID = 3;

    // host bus cycle states
    typedef enum logic [2:0] {
        HPP_IDLE = 3'h1,
        HPP_SETUP = 3'h2,
        HPP_HIGH = 3'h4
    } hpp_bus_state_t;
endpackage

// ### core/hpp_if.sv
// ***************************************************************
// link between the port device and its processor/peripheral end
// ***************************************************************
// assumes both ends run on the same clock; resolves the shared lines
`timescale 1ns/1ps
interface hpp_if;
    // processor bus
    logic [1:0] regSel;
    logic readNotWrite;
    logic enableClk;
    logic select_high_one;
    logic select_high_two;
    logic select_low_three;
    logic [7:0] busWrData;
    logic [7:0] busRdData;
    logic busRdOe;
    logic irqReqN;
    // port lines: data and enable from each driving end, plus the resolved level
    logic [7:0] portADevOut;
    logic [7:0] portADevOe;
    logic [7:0] portAPerOut;
    logic [7:0] portAPerOe;
    logic [7:0] portALevel;
    logic [7:0] portBDevOut;
    logic [7:0] portBDevOe;
    logic [7:0] portBLevel;
    // handshake lines
    logic port_a_ready_strobe;
    logic port_a_taken_ack;
    logic port_a_taken_ack_oe;
    logic port_b_accept_strobe;
    logic port_b_data_valid;
    logic port_b_data_valid_oe;

    // undriven lines float high through the pull-ups
    assign portALevel = (portADevOe & portADevOut) | (portAPerOe & portAPerOut)
                      | ~(portADevOe | portAPerOe);
    assign portBLevel = (portBDevOe & portBDevOut) | ~portBDevOe;

    modport dev (
        input regSel, readNotWrite, enableClk, select_high_one, select_high_two,
        input select_low_three, busWrData, portALevel, portBLevel,
        input port_a_ready_strobe, port_b_accept_strobe,
        output busRdData, busRdOe, irqReqN, portADevOut, portADevOe, portBDevOut, portBDevOe,
        output port_a_taken_ack, port_a_taken_ack_oe, port_b_data_valid, port_b_data_valid_oe
    );
    modport host (
        output regSel, readNotWrite, enableClk, select_high_one, select_high_two,
        output select_low_three, busWrData, portAPerOut, portAPerOe,
        output port_a_ready_strobe, port_b_accept_strobe,
        input busRdData, busRdOe, irqReqN, portALevel, portBLevel,
        input port_a_taken_ack, port_a_taken_ack_oe, port_b_data_valid, port_b_data_valid_oe
    );
endinterface

// ### core/hpp_edge_detect.sv
// ***************************************************************
// strobe edge detector with selectable active edge
// ***************************************************************
// assumes the strobe comes from logic on the same clock
`timescale 1ns/1ps
module hpp_edge_detect
    import hpp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // strobe in, edge pulse out
    input wire logic level,
    input wire logic risingSel,
    output logic pulse
);
    logic prev;

    // previous level; resets low so an idle low strobe gives no false edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign pulse = risingSel ? (level & ~prev) : (~level & prev);
endmodule

// ### core/hpp_device.sv
// ***************************************************************
// handshake parallel port: the device end
// ***************************************************************
// two 8-bit ports with direction registers, strobe flags and handshakes.
// assumes the processor end runs on the same clock and holds address,
// selects and write data steady while the enable clock is high.
//
// Functional notes
// - reset turns every port line to input
// - reset clears data and direction registers
// - direction bit one means output, zero input
// - data register drives the output lines
// - write data latched at enable falling edge
// - processor gives address, then data in phase two
// - port B write drives data valid low
// - data valid stays low until acceptance strobe
// - acceptance strobe edge returns data valid high
// - acceptance strobe raises an interrupt
// - peripheral strobes acceptance after reading port B
// - peripheral sets port A data before strobing
// - ready strobe edge raises port A interrupt
// - ready strobe sets taken acknowledge high
// - pending interrupt drives request output low
// - peripheral holds port A until read
// - port A read returns the line levels
// - port A read drives taken acknowledge low
// - software loads data ones before direction ones
// - access only with selects high, high, low
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module hpp_device
    import hpp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // processor and peripheral link
    hpp_if.dev link
);
    // ***************************************************************
    // bus capture
    // ***************************************************************
    logic selected;
    logic enablePrev;
    logic selQ;
    logic rwQ;
    logic [1:0] regQ;
    logic [7:0] dataQ;
    logic busDone;
    logic doWrite;
    logic doRead;

    assign selected = link.select_high_one & link.select_high_two
                    & ~link.select_low_three;

    // hold the access as seen while the enable clock was high
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enablePrev <= 1'b0;
            selQ <= 1'b0;
            rwQ <= 1'b1;
            regQ <= REG_PORT_A;
            dataQ <= BYTE_ZERO;
        end else begin
            enablePrev <= link.enableClk;
            if (link.enableClk) begin
                selQ <= selected;
                rwQ <= link.readNotWrite;
                regQ <= link.regSel;
                dataQ <= link.busWrData; // data bus valid in phase two
            end
        end
    end

    // the access takes effect on the falling edge of the enable clock
    assign busDone = enablePrev & ~link.enableClk & selQ;
    assign doWrite = busDone & ~rwQ;
    assign doRead = busDone & rwQ;

    // ***************************************************************
    // port registers
    // ***************************************************************
    logic [7:0] dataA;
    logic [7:0] dataB;
    logic [7:0] dirA;
    logic [7:0] dirB;
    logic [2:0] ctrlA;
    logic [2:0] ctrlB;
    logic writeDataB;
    logic readDataA;
    logic readDataB;

    assign writeDataB = doWrite && regQ == REG_PORT_B && ctrlB[CTRL_DATA_SEL];
    assign readDataA = doRead && regQ == REG_PORT_A && ctrlA[CTRL_DATA_SEL];
    assign readDataB = doRead && regQ == REG_PORT_B && ctrlB[CTRL_DATA_SEL];

    // data and direction registers, cleared by reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dataA <= BYTE_ZERO;
            dataB <= BYTE_ZERO;
            dirA <= BYTE_ZERO;
            dirB <= BYTE_ZERO;
        end else if (doWrite) begin
            if (regQ == REG_PORT_A && ctrlA[CTRL_DATA_SEL]) begin
                dataA <= dataQ;
            end else if (regQ == REG_PORT_A) begin
                dirA <= dataQ;
            end else if (regQ == REG_PORT_B && ctrlB[CTRL_DATA_SEL]) begin
                dataB <= dataQ;
            end else if (regQ == REG_PORT_B) begin
                dirB <= dataQ;
            end
        end
    end

    // control registers; only the low three bits are stored
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrlA <= CTRL_RESET;
            ctrlB <= CTRL_RESET;
        end else if (doWrite) begin
            if (regQ == REG_CTRL_A) begin
                ctrlA <= dataQ[2:0];
            end else if (regQ == REG_CTRL_B) begin
                ctrlB <= dataQ[2:0];
            end
        end
    end

    // direction registers reset to zero, so every line is an input in reset
    assign link.portADevOe = dirA;
    assign link.portBDevOe = dirB;
    assign link.portADevOut = dataA;
    assign link.portBDevOut = dataB;

    // ***************************************************************
    // strobes, flags and handshakes
    // ***************************************************************
    logic edgeA;
    logic edgeB;
    logic flagA;
    logic flagB;
    logic ackA;
    logic validB;

    hpp_edge_detect strobeADetect (
        .clock(clock),
        .reset_n(reset_n),
        .level(link.port_a_ready_strobe),
        .risingSel(ctrlA[CTRL_EDGE_RISING]),
        .pulse(edgeA)
    );

    hpp_edge_detect strobeBDetect (
        .clock(clock),
        .reset_n(reset_n),
        .level(link.port_b_accept_strobe),
        .risingSel(ctrlB[CTRL_EDGE_RISING]),
        .pulse(edgeB)
    );

    // strobe flags: a new edge wins over a clearing read in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flagA <= 1'b0;
            flagB <= 1'b0;
        end else begin
            if (edgeA) begin
                flagA <= 1'b1;
            end else if (readDataA) begin
                flagA <= 1'b0;
            end
            if (edgeB) begin
                flagB <= 1'b1;
            end else if (readDataB) begin
                flagB <= 1'b0;
            end
        end
    end

    // taken acknowledge: strobe sets, data read clears, strobe wins a tie
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ackA <= 1'b0;
        end else if (edgeA) begin
            ackA <= 1'b1;
        end else if (readDataA) begin
            ackA <= 1'b0;
        end
    end

    // data valid: a handshake-mode write wins over a late strobe, or new data is lost;
    // outside handshake mode a write leaves it high so the first handshake starts clean
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            validB <= 1'b1;
        end else if (writeDataB && ctrlB[CTRL_HANDSHAKE]) begin
            validB <= 1'b0;
        end else if (edgeB) begin
            validB <= 1'b1;
        end
    end

    // second control lines drive only in handshake mode
    assign link.port_a_taken_ack = ackA;
    assign link.port_a_taken_ack_oe = ctrlA[CTRL_HANDSHAKE];
    assign link.port_b_data_valid = validB;
    assign link.port_b_data_valid_oe = ctrlB[CTRL_HANDSHAKE];
    assign link.irqReqN = ~(flagA | flagB);

    // ***************************************************************
    // read data
    // ***************************************************************
    logic [7:0] next_rdData;
    logic [7:0] rdData;

    // read mux; output lines of port B read back the register, not the pins
    always_comb begin
        if (link.regSel == REG_PORT_A && ctrlA[CTRL_DATA_SEL]) begin
            next_rdData = link.portALevel;
        end else if (link.regSel == REG_PORT_A) begin
            next_rdData = dirA;
        end else if (link.regSel == REG_CTRL_A) begin
            next_rdData = {flagA, 4'h0, ctrlA};
        end else if (link.regSel == REG_PORT_B && ctrlB[CTRL_DATA_SEL]) begin
            next_rdData = (dataB & dirB) | (link.portBLevel & ~dirB);
        end else if (link.regSel == REG_PORT_B) begin
            next_rdData = dirB;
        end else begin
            next_rdData = {flagB, 4'h0, ctrlB};
        end
    end

    // registered so the bus sees a settled value one cycle after the address
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= BYTE_ZERO;
        end else begin
            rdData <= next_rdData;
        end
    end

    assign link.busRdData = rdData;
    assign link.busRdOe = selected & link.readNotWrite & link.enableClk;
endmodule

// ### core/hpp_host_end.sv
// ***************************************************************
// handshake parallel port: processor and peripheral end
// ***************************************************************
// runs bus cycles and drives peripheral lines on software orders.
// assumes software polls the busy bit before starting a new cycle.
`timescale 1ns/1ps
module hpp_host_end
    import hpp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // software register port
    input wire logic [3:0] swAddr,
    input wire logic [7:0] swWrData,
    input wire logic swWrite,
    input wire logic swRead,
    output logic [7:0] swRdData,
    // device link
    hpp_if.host link
);
    hpp_bus_state_t state;
    logic [1:0] highCount;
    logic [2:0] target;
    logic [7:0] wrData;
    logic [7:0] rdCapture;
    logic [7:0] paOut;
    logic [7:0] paOe;
    logic [1:0] strobes;
    logic startCycle;

    assign startCycle = swWrite && swAddr == HOST_REG_GO && state == HPP_IDLE;

    // software settings; a go while busy is ignored
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            target <= 3'h0;
            wrData <= BYTE_ZERO;
            paOut <= BYTE_ONES;
            paOe <= BYTE_ZERO;
            strobes <= 2'h0;
        end else if (swWrite) begin
            if (swAddr == HOST_REG_TARGET) begin
                target <= swWrData[2:0];
            end else if (swAddr == HOST_REG_WDATA) begin
                wrData <= swWrData;
            end else if (swAddr == HOST_REG_PA_OUT) begin
                paOut <= swWrData; // new port A data before the strobe
            end else if (swAddr == HOST_REG_PA_OE) begin
                paOe <= swWrData; // held until software changes it
            end else if (swAddr == HOST_REG_STROBES) begin
                strobes <= swWrData[1:0]; // acceptance after reading
            end
        end
    end

    // bus cycle: address first, then enable high with data, then fall
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= HPP_IDLE;
            highCount <= ENABLE_COUNT_ZERO;
        end else begin
            case (state)
                HPP_IDLE: begin
                    if (startCycle) begin
                        state <= HPP_SETUP;
                    end
                end
                HPP_SETUP: begin
                    state <= HPP_HIGH;
                    highCount <= ENABLE_COUNT_ZERO;
                end
                HPP_HIGH: begin
                    if (highCount == ENABLE_COUNT_LAST) begin
                        state <= HPP_IDLE;
                    end else begin
                        highCount <= highCount + ENABLE_COUNT_STEP;
                    end
                end
                default: begin
                    state <= HPP_IDLE;
                end
            endcase
        end
    end

    // read data caught in the last high cycle, before the enable falls
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdCapture <= BYTE_ZERO;
        end else if (state == HPP_HIGH && highCount == ENABLE_COUNT_LAST
                     && target[TARGET_READ] && link.busRdOe) begin
            rdCapture <= link.busRdData;
        end
    end

    // software read port, data one cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            swRdData <= BYTE_ZERO;
        end else if (swRead) begin
            if (swAddr == HOST_REG_TARGET) begin
                swRdData <= {5'h0, target};
            end else if (swAddr == HOST_REG_WDATA) begin
                swRdData <= wrData;
            end else if (swAddr == HOST_REG_STATUS) begin
                swRdData <= {4'h0, link.port_b_data_valid, link.port_a_taken_ack,
                             ~link.irqReqN, state != HPP_IDLE};
            end else if (swAddr == HOST_REG_RDATA) begin
                swRdData <= rdCapture;
            end else if (swAddr == HOST_REG_PA_OUT) begin
                swRdData <= paOut;
            end else if (swAddr == HOST_REG_PA_OE) begin
                swRdData <= paOe;
            end else if (swAddr == HOST_REG_STROBES) begin
                swRdData <= {6'h0, strobes};
            end else if (swAddr == HOST_REG_PB_LEVEL) begin
                swRdData <= link.portBLevel;
            end else begin
                swRdData <= BYTE_ZERO;
            end
        end
    end

    // bus pins; address and data stay put after the cycle ends
    assign link.regSel = target[1:0];
    assign link.readNotWrite = target[TARGET_READ];
    assign link.busWrData = wrData;
    assign link.enableClk = (state == HPP_HIGH);
    assign link.select_high_one = (state != HPP_IDLE);
    assign link.select_high_two = (state != HPP_IDLE);
    assign link.select_low_three = (state == HPP_IDLE);
    // peripheral side of the port lines
    assign link.portAPerOut = paOut;
    assign link.portAPerOe = paOe;
    assign link.port_a_ready_strobe = strobes[STROBE_READY];
    assign link.port_b_accept_strobe = strobes[STROBE_ACCEPT];
endmodule

// ### dv/hpp_checker.sv
// ***************************************************************
// concurrent checks on the device end of the port link
// ***************************************************************
// assumes one clock; inputs mirror the interface signals
`timescale 1ns/1ps
module hpp_checker
    import hpp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // processor bus
    input wire logic [1:0] regSel,
    input wire logic readNotWrite,
    input wire logic enableClk,
    input wire logic irqReqN,
    // port lines
    input wire logic [7:0] portADevOut,
    input wire logic [7:0] portADevOe,
    input wire logic [7:0] portBDevOut,
    input wire logic [7:0] portBDevOe,
    // handshake lines
    input wire logic port_a_ready_strobe,
    input wire logic port_a_taken_ack,
    input wire logic port_a_taken_ack_oe,
    input wire logic port_b_accept_strobe,
    input wire logic port_b_data_valid,
    input wire logic port_b_data_valid_oe
);
    // strobes are assumed on the default falling edge
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_reset_inputs: assert property ($rose(reset_n) |-> portADevOe == 8'h00 &&
        portBDevOe == 8'h00 && !port_a_taken_ack_oe && !port_b_data_valid_oe)
        else $error("line not input after reset");
    a_reset_clear: assert property ($rose(reset_n) |-> portADevOut == 8'h00
        && portBDevOut == 8'h00) else $error("data not cleared by reset");
    a_write_latch: assert property ($changed(portADevOut) || $changed(portBDevOut)
        || $changed(portBDevOe) || $changed(portADevOe)
        |-> !$past(enableClk) && $past(enableClk, 2))
        else $error("register changed off enable fall");
    a_valid_low: assert property ($fell(enableClk) && $past(!readNotWrite)
        && $past(regSel) == REG_PORT_B && port_b_data_valid_oe |=> !port_b_data_valid)
        else $error("data valid not low after write");
    a_valid_holds: assert property ($rose(port_b_data_valid)
        |-> $past(port_b_accept_strobe) != $past(port_b_accept_strobe, 2))
        else $error("data valid rose without strobe");
    a_valid_return: assert property ($fell(port_b_accept_strobe) && !port_b_data_valid
        |-> ##[1:3] port_b_data_valid) else $error("data valid did not return");
    a_irq_raise: assert property ($fell(port_a_ready_strobe)
        || $fell(port_b_accept_strobe) |-> ##[1:3] !irqReqN) else $error("no request");
    a_ack_set: assert property ($fell(port_a_ready_strobe)
        |-> ##[1:3] port_a_taken_ack) else $error("ack not set");
    a_ack_clear: assert property ($fell(enableClk) && $past(readNotWrite)
        && $past(regSel) == REG_PORT_A |=> !port_a_taken_ack) else $error("ack not cleared");
    a_irq_release: assert property ($rose(irqReqN) |-> $past(readNotWrite, 2)
        && $past(enableClk, 2) && !$past(enableClk)) else $error("request cleared early");
endmodule

// ### dv/tb_handshake_parallel_port.sv
// ***************************************************************
// testbench: both ends joined, driven through the software port
// ***************************************************************
// assumes the host end reports busy until its bus cycle ends
`timescale 1ns/1ps
module tb_handshake_parallel_port
    import hpp_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] swAddr = 4'h0;
    logic [7:0] swWrData = 8'h00;
    logic swWrite = 1'b0;
    logic swRead = 1'b0;
    logic [7:0] swRdData;
    logic [7:0] rd;
    int n_fail = 0;
    int tests_run = 0;
    hpp_if link();
    always #25 clock = ~clock;
    hpp_device i_hpp_device (.clock(clock), .reset_n(reset_n), .link(link));
    hpp_host_end i_hpp_host_end (.clock(clock), .reset_n(reset_n), .swAddr(swAddr),
        .swWrData(swWrData), .swWrite(swWrite), .swRead(swRead), .swRdData(swRdData),
        .link(link));
    hpp_checker i_hpp_checker (.clock(clock), .reset_n(reset_n), .regSel(link.regSel),
        .readNotWrite(link.readNotWrite), .enableClk(link.enableClk), .irqReqN(link.irqReqN),
        .portADevOut(link.portADevOut), .portADevOe(link.portADevOe),
        .portBDevOut(link.portBDevOut), .portBDevOe(link.portBDevOe),
        .port_a_ready_strobe(link.port_a_ready_strobe),
        .port_a_taken_ack(link.port_a_taken_ack),
        .port_a_taken_ack_oe(link.port_a_taken_ack_oe),
        .port_b_accept_strobe(link.port_b_accept_strobe),
        .port_b_data_valid(link.port_b_data_valid),
        .port_b_data_valid_oe(link.port_b_data_valid_oe));

    // ***************************************************************
    // software port tasks
    // ***************************************************************
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        swWrite <= 1'b1;
        swAddr <= a;
        swWrData <= d;
        @(posedge clock);
        swWrite <= 1'b0;
    endtask
    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        swRead <= 1'b1;
        swAddr <= a;
        @(posedge clock);
        swRead <= 1'b0;
        // read data stand in the cycle after the strobe; take them at its closing edge
        @(posedge clock);
        d = swRdData;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one device bus cycle; polling is bounded so a stuck busy cannot hang
    task automatic dev_op(input logic [1:0] r, input logic rdn, input logic [7:0] d);
        sw_wr(HOST_REG_TARGET, {5'h00, rdn, r});
        sw_wr(HOST_REG_WDATA, d);
        sw_wr(HOST_REG_GO, 8'h00);
        for (int i = 0; i < 20; i++) begin
            sw_rd(HOST_REG_STATUS, rd);
            if (rd[STATUS_BUSY] === 1'b0) break;
        end
        chk8("busy", 8'h00, {7'h00, rd[STATUS_BUSY]});
        if (rdn) sw_rd(HOST_REG_RDATA, rd);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ***************************************************************
    // tests
    // ***************************************************************
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        dev_op(REG_CTRL_A, 1'b1, 8'h00);
        chk8("ctrl a", 8'h00, rd);
        dev_op(REG_CTRL_B, 1'b1, 8'h00);
        chk8("ctrl b", 8'h00, rd);
        dev_op(REG_PORT_B, 1'b1, 8'h00);
        chk8("dir b", 8'h00, rd);
        sw_rd(HOST_REG_PB_LEVEL, rd);
        chk8("pb lines", 8'hff, rd);
        $display("reset test done");
        // data first, then low nibble as output, then handshake on
        dev_op(REG_CTRL_B, 1'b0, 8'h04);
        dev_op(REG_PORT_B, 1'b0, 8'ha5);
        dev_op(REG_CTRL_B, 1'b0, 8'h00);
        dev_op(REG_PORT_B, 1'b0, 8'h0f);
        dev_op(REG_CTRL_B, 1'b0, 8'h06);
        sw_rd(HOST_REG_PB_LEVEL, rd);
        chk8("pb out", 8'hf5, rd);
        dev_op(REG_PORT_B, 1'b0, 8'h3c);
        sw_rd(HOST_REG_STATUS, rd);
        chk8("valid low", 8'h00, rd & 8'h0a);
        repeat (6) @(posedge clock);
        sw_rd(HOST_REG_STATUS, rd);
        chk8("valid held", 8'h00, rd & 8'h0a);
        sw_wr(HOST_REG_STROBES, 8'h02);
        sw_wr(HOST_REG_STROBES, 8'h00);
        repeat (3) @(posedge clock);
        sw_rd(HOST_REG_STATUS, rd);
        chk8("valid back", 8'h0a, rd & 8'h0a);
        dev_op(REG_PORT_B, 1'b1, 8'h00);
        chk8("pb read", 8'hfc, rd);
        sw_rd(HOST_REG_STATUS, rd);
        chk8("irq clear b", 8'h08, rd & 8'h0a);
        $display("output handshake test done");
        dev_op(REG_CTRL_A, 1'b0, 8'h06);
        sw_wr(HOST_REG_PA_OUT, 8'h5a);
        sw_wr(HOST_REG_PA_OE, 8'hff);
        sw_wr(HOST_REG_STROBES, 8'h01);
        sw_wr(HOST_REG_STROBES, 8'h00);
        repeat (3) @(posedge clock);
        sw_rd(HOST_REG_STATUS, rd);
        chk8("ack set", 8'h06, rd & 8'h06);
        dev_op(REG_PORT_A, 1'b1, 8'h00);
        chk8("pa read", 8'h5a, rd);
        sw_wr(HOST_REG_PA_OE, 8'h00);
        sw_rd(HOST_REG_STATUS, rd);
        chk8("ack low", 8'h00, rd & 8'h06);
        $display("input handshake test done");
        give_verdict();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #2000000;
        n_fail++;
        give_verdict();
    end
endmodule
